//--- shared/sdsp_pkg.sv
// Purpose: shared constants and types of the servo driver serial port
// Assumes: 16-bit write-only frames, most significant bit shifted first
// Notes:   both ends and the testbench use these names
package sdsp_pkg;

  // ---------------------------------------------------------------
  // frame layout
  // ---------------------------------------------------------------
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned NUM_PORTS   = 8;
  localparam int unsigned SEL_HIGH    = 15;
  localparam int unsigned SEL_MID     = 14;
  localparam int unsigned SEL_LOW     = 13;
  localparam int unsigned BANK_BIT    = 3;
  localparam int unsigned COMMUTE_BIT = 12;
  localparam int unsigned HW_COMM_BIT = 4;
  localparam logic [2:0]  PORT_ZERO   = 3'h0;
  localparam logic [2:0]  PORT_TOP    = 3'h7;
  localparam logic [2:0]  PORT_TEST   = 3'h6;
  localparam logic [15:0] PORT_RST    = 16'h0000;

  // ---------------------------------------------------------------
  // link timing, write direction
  // ---------------------------------------------------------------
  localparam int unsigned CLK_NS      = 25;
  localparam int unsigned SCLK_HALF_NS = 50;
  localparam int unsigned LEAD_NS     = 35;
  localparam int unsigned TAIL_NS     = 100;
  localparam int unsigned GAP_NS      = 200;
  localparam int unsigned HALF_CYC = (SCLK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned LEAD_CYC = (LEAD_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned TAIL_CYC = (TAIL_NS + CLK_NS - 1) / CLK_NS;
  localparam int unsigned GAP_CYC  = (GAP_NS + CLK_NS - 1) / CLK_NS;

  // ---------------------------------------------------------------
  // host command registers
  // ---------------------------------------------------------------
  localparam logic [3:0] ADDR_FRAME  = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h1;
  localparam int unsigned STAT_BUSY  = 0;
  localparam int unsigned STAT_DONE  = 1;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_LEAD = 3'b001,
    HST_HIGH = 3'b010,
    HST_LOW  = 3'b011,
    HST_TAIL = 3'b100,
    HST_GAP  = 3'b101
  } sdsp_host_st_t;

  typedef enum logic [2:0] {
    COMM_PH0 = 3'b000,
    COMM_PH1 = 3'b001,
    COMM_PH2 = 3'b010,
    COMM_PH3 = 3'b011,
    COMM_PH4 = 3'b100,
    COMM_PH5 = 3'b101
  } sdsp_comm_t;

endpackage

//--- shared/sdsp_link_if.sv
// Purpose: three-wire write link between host and driver
// Assumes: all lines driven by the host only
// Notes:   no clocking block; each end samples as it needs
`timescale 1ns/1ps
interface sdsp_link_if;
  logic serialClk;
  logic serialDataLine;
  logic serialSelectLow;

  modport host (
    output serialClk,
    output serialDataLine,
    output serialSelectLow
  );

  modport dev (
    input serialClk,
    input serialDataLine,
    input serialSelectLow
  );
endinterface

//--- hdl/sdsp_host.sv
// Purpose: host end, turns a register write into one 16-bit frame
// Assumes: clk_sys at 40 MHz, sclk made by a divider
// Notes:   a write to the frame register while busy is ignored
`timescale 1ns/1ps
module sdsp_host (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [15:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdata,
  // link
  sdsp_link_if.host        link
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  sdsp_pkg::sdsp_host_st_t stFf, nxt_st;
  logic [3:0]  timerFf,  nxt_timer;
  logic [3:0]  bitCntFf, nxt_bitCnt;
  logic [15:0] shiftFf,  nxt_shift;
  logic [15:0] lastFf,   nxt_last;
  logic        sclkFf,   nxt_sclk;
  logic        dataFf,   nxt_data;
  logic        selFf,    nxt_sel;
  logic        doneFf,   nxt_done;
  logic [15:0] rdataFf,  nxt_rdata;
  logic        busy;
  logic        startReq;

  assign busy     = (stFf != sdsp_pkg::HST_IDLE);
  assign startReq = regWr && (regAddr == sdsp_pkg::ADDR_FRAME) && !busy;

  // ---------------------------------------------------------------
  // frame sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st     = stFf;
    nxt_timer  = timerFf;
    nxt_bitCnt = bitCntFf;
    nxt_shift  = shiftFf;
    nxt_last   = lastFf;
    nxt_sclk   = sclkFf;
    nxt_data   = dataFf;
    nxt_sel    = selFf;
    nxt_done   = doneFf;
    if (timerFf != 4'h0) begin
      nxt_timer = timerFf - 4'h1;
    end
    case (stFf)
      sdsp_pkg::HST_IDLE: begin
        if (startReq) begin
          nxt_shift  = regWdata;
          nxt_last   = regWdata;
          nxt_data   = regWdata[15];
          nxt_sel    = 1'b0;
          nxt_sclk   = 1'b0;
          nxt_bitCnt = 4'h0;
          nxt_timer  = 4'(sdsp_pkg::LEAD_CYC - 1);
          nxt_st     = sdsp_pkg::HST_LEAD;
        end
      end
      sdsp_pkg::HST_LEAD, sdsp_pkg::HST_LOW: begin
        if (timerFf == 4'h0) begin
          nxt_sclk  = 1'b1;
          nxt_timer = 4'(sdsp_pkg::HALF_CYC - 1);
          nxt_st    = sdsp_pkg::HST_HIGH;
        end
      end
      sdsp_pkg::HST_HIGH: begin
        if (timerFf == 4'h0) begin
          nxt_sclk = 1'b0;
          if (bitCntFf == 4'hf) begin
            nxt_timer = 4'(sdsp_pkg::TAIL_CYC - 1);
            nxt_st    = sdsp_pkg::HST_TAIL;
          end else begin
            // data moves on the falling edge, half a period clear of rise
            nxt_shift  = {shiftFf[14:0], 1'b0};
            nxt_data   = shiftFf[14];
            nxt_bitCnt = bitCntFf + 4'h1;
            nxt_timer  = 4'(sdsp_pkg::HALF_CYC - 1);
            nxt_st     = sdsp_pkg::HST_LOW;
          end
        end
      end
      sdsp_pkg::HST_TAIL: begin
        if (timerFf == 4'h0) begin
          nxt_sel   = 1'b1;
          nxt_timer = 4'(sdsp_pkg::GAP_CYC - 1);
          nxt_st    = sdsp_pkg::HST_GAP;
        end
      end
      sdsp_pkg::HST_GAP: begin
        if (timerFf == 4'h0) begin
          nxt_st = sdsp_pkg::HST_IDLE;
        end
      end
      default: begin
        nxt_st  = sdsp_pkg::HST_IDLE;
        nxt_sel = 1'b1;
      end
    endcase
    // completion flag: set wins over the clear in the same cycle
    if (regWr && (regAddr == sdsp_pkg::ADDR_STATUS) && regWdata[sdsp_pkg::STAT_DONE]) begin
      nxt_done = 1'b0;
    end
    if ((stFf == sdsp_pkg::HST_GAP) && (timerFf == 4'h0)) begin
      nxt_done = 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  always_comb begin
    nxt_rdata = 16'h0000;
    if (regRd) begin
      case (regAddr)
        sdsp_pkg::ADDR_FRAME:  nxt_rdata = lastFf;
        sdsp_pkg::ADDR_STATUS: nxt_rdata = {14'h0000, doneFf, busy};
        default:               nxt_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      stFf     <= sdsp_pkg::HST_IDLE;
      timerFf  <= 4'h0;
      bitCntFf <= 4'h0;
      shiftFf  <= 16'h0000;
      lastFf   <= 16'h0000;
      sclkFf   <= 1'b0;
      dataFf   <= 1'b0;
      selFf    <= 1'b1;
      doneFf   <= 1'b0;
      rdataFf  <= 16'h0000;
    end else begin
      stFf     <= nxt_st;
      timerFf  <= nxt_timer;
      bitCntFf <= nxt_bitCnt;
      shiftFf  <= nxt_shift;
      lastFf   <= nxt_last;
      sclkFf   <= nxt_sclk;
      dataFf   <= nxt_data;
      selFf    <= nxt_sel;
      doneFf   <= nxt_done;
      rdataFf  <= nxt_rdata;
    end
  end

  assign regRdata             = rdataFf;
  assign link.serialClk       = sclkFf;
  assign link.serialDataLine  = dataFf;
  assign link.serialSelectLow = selFf;

endmodule

//--- hdl/sdsp_device.sv
// Purpose: driver end, receives frames and holds the eight port registers
// Assumes: link lines asynchronous to clk_sys, sclk at most clk_sys/4
// Notes:   also runs the spindle commutation phase sequence
`timescale 1ns/1ps
module sdsp_device (
  // clock and reset
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  // link
  sdsp_link_if.dev                 link,
  // back-emf zero crossing from the spindle sense, asynchronous
  input  wire logic                zeroCross,
  // port register contents
  output logic [7:0][15:0]         portRegs,
  output logic                     bankSelect,
  // frame and commutation events
  output logic                     frameLoaded,
  output logic [2:0]               frameDest,
  output logic                     commStep,
  output logic [2:0]               commPhase
);

  // ---------------------------------------------------------------
  // input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] clkSyncFf,  nxt_clkSync;
  logic [1:0] dataSyncFf, nxt_dataSync;
  logic [1:0] selSyncFf,  nxt_selSync;
  logic [1:0] zcSyncFf,   nxt_zcSync;
  logic       clkPrevFf,  nxt_clkPrev;
  logic       zcPrevFf,   nxt_zcPrev;
  logic       sclkRise;
  logic       zcRise;

  // stage 0 feeds stage 1 only; all logic reads stage 1
  always_comb begin
    nxt_clkSync  = {clkSyncFf[0], link.serialClk};
    nxt_dataSync = {dataSyncFf[0], link.serialDataLine};
    nxt_selSync  = {selSyncFf[0], link.serialSelectLow};
    nxt_zcSync   = {zcSyncFf[0], zeroCross};
    nxt_clkPrev  = clkSyncFf[1];
    nxt_zcPrev   = zcSyncFf[1];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      clkSyncFf  <= 2'h0;
      dataSyncFf <= 2'h0;
      selSyncFf  <= 2'h3;
      zcSyncFf   <= 2'h0;
      clkPrevFf  <= 1'b0;
      zcPrevFf   <= 1'b0;
    end else begin
      clkSyncFf  <= nxt_clkSync;
      dataSyncFf <= nxt_dataSync;
      selSyncFf  <= nxt_selSync;
      zcSyncFf   <= nxt_zcSync;
      clkPrevFf  <= nxt_clkPrev;
      zcPrevFf   <= nxt_zcPrev;
    end
  end

  // data and select share the clock's delay, so they stay aligned to it
  assign sclkRise = clkSyncFf[1] && !clkPrevFf;
  assign zcRise   = zcSyncFf[1] && !zcPrevFf;

  // ---------------------------------------------------------------
  // frame receiver
  // ---------------------------------------------------------------
  logic [4:0]  bitCntFf, nxt_bitCnt;
  logic [15:0] shiftFf,  nxt_shift;
  logic        loadFf,   nxt_load;

  always_comb begin
    nxt_bitCnt = bitCntFf;
    nxt_shift  = shiftFf;
    nxt_load   = 1'b0;
    if (selSyncFf[1]) begin
      // a partial frame is simply forgotten here
      nxt_bitCnt = 5'h00;
    end else if (sclkRise && (bitCntFf < 5'(sdsp_pkg::FRAME_BITS))) begin
      nxt_shift  = {shiftFf[14:0], dataSyncFf[1]};
      nxt_bitCnt = bitCntFf + 5'h01;
      // clocks past the sixteenth are ignored until select rises
      nxt_load   = (bitCntFf == 5'(sdsp_pkg::FRAME_BITS - 1));
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bitCntFf <= 5'h00;
      shiftFf  <= 16'h0000;
      loadFf   <= 1'b0;
    end else begin
      bitCntFf <= nxt_bitCnt;
      shiftFf  <= nxt_shift;
      loadFf   <= nxt_load;
    end
  end

  // ---------------------------------------------------------------
  // port decode
  // ---------------------------------------------------------------
  function automatic logic [2:0] destOf(input logic [15:0] frame, input logic bank);
    logic [1:0] pair;
    pair = {frame[sdsp_pkg::SEL_MID], frame[sdsp_pkg::SEL_LOW]};
    destOf = sdsp_pkg::PORT_ZERO;
    if (frame[sdsp_pkg::SEL_HIGH]) begin
      destOf = sdsp_pkg::PORT_TOP;
    end else if (pair == 2'h0) begin
      destOf = sdsp_pkg::PORT_ZERO;
    end else if (!bank) begin
      destOf = {pair, 1'b0} - 3'h1;
    end else begin
      destOf = {pair, 1'b0};
    end
  endfunction

  // one unpacked entry per port so each register has its own process
  logic [15:0]      portFf [sdsp_pkg::NUM_PORTS];
  logic [2:0]       dest;

  // bank bit lives in port 0 and steers later frames with bit 15 clear and a nonzero bit 14:13 pair
  assign dest = destOf(shiftFf, portFf[0][sdsp_pkg::BANK_BIT]);

  // ---------------------------------------------------------------
  // port registers
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < sdsp_pkg::NUM_PORTS; gi++) begin : g_port
      logic [15:0] nxt_port;
      always_comb begin
        nxt_port = portFf[gi];
        // the test port is not user programmable and keeps its reset value
        if (loadFf && (dest == 3'(gi)) && (dest != sdsp_pkg::PORT_TEST)) begin
          nxt_port = shiftFf;
        end
      end
      always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
          portFf[gi] <= sdsp_pkg::PORT_RST;
        end else begin
          portFf[gi] <= nxt_port;
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // load report
  // ---------------------------------------------------------------
  logic       loadedFf, nxt_loaded;
  logic [2:0] destFf,   nxt_destOut;
  logic       stepFf,   nxt_step;

  always_comb begin
    nxt_loaded  = loadFf;
    nxt_destOut = destFf;
    if (loadFf) begin
      nxt_destOut = dest;
    end
    // a write to port 0 with the manual bit set is one software step
    nxt_step = loadFf && (dest == sdsp_pkg::PORT_ZERO)
               && shiftFf[sdsp_pkg::COMMUTE_BIT];
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      loadedFf <= 1'b0;
      destFf   <= 3'h0;
      stepFf   <= 1'b0;
    end else begin
      loadedFf <= nxt_loaded;
      destFf   <= nxt_destOut;
      stepFf   <= nxt_step;
    end
  end

  // ---------------------------------------------------------------
  // commutation sequence
  // ---------------------------------------------------------------
  sdsp_pkg::sdsp_comm_t phaseFf, nxt_phase;
  logic                 advance;

  // hardware mode follows back-emf, software mode follows manual steps
  assign advance = portFf[0][sdsp_pkg::HW_COMM_BIT] ? zcRise : stepFf;

  always_comb begin
    nxt_phase = phaseFf;
    if (advance) begin
      case (phaseFf)
        sdsp_pkg::COMM_PH0: nxt_phase = sdsp_pkg::COMM_PH1;
        sdsp_pkg::COMM_PH1: nxt_phase = sdsp_pkg::COMM_PH2;
        sdsp_pkg::COMM_PH2: nxt_phase = sdsp_pkg::COMM_PH3;
        sdsp_pkg::COMM_PH3: nxt_phase = sdsp_pkg::COMM_PH4;
        sdsp_pkg::COMM_PH4: nxt_phase = sdsp_pkg::COMM_PH5;
        sdsp_pkg::COMM_PH5: nxt_phase = sdsp_pkg::COMM_PH0;
        default:            nxt_phase = sdsp_pkg::COMM_PH0;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phaseFf <= sdsp_pkg::COMM_PH0;
    end else begin
      phaseFf <= nxt_phase;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    for (int p = 0; p < sdsp_pkg::NUM_PORTS; p++) begin
      portRegs[p] = portFf[p];
    end
  end
  assign bankSelect  = portFf[0][sdsp_pkg::BANK_BIT];
  assign frameLoaded = loadedFf;
  assign frameDest   = destFf;
  assign commStep    = stepFf;
  assign commPhase   = phaseFf;

endmodule

//--- testbench/sdsp_assertions.sv
// Purpose: link and load checks for the serial port
// Assumes: link lines sampled on clk_sys, frame msb first
// Notes:   the frame is rebuilt from the wires
`timescale 1ns/1ps
module sdsp_assertions (
  // clock and reset
  input wire logic             clk_sys,
  input wire logic             rst_n,
  // link
  input wire logic             serialClk,
  input wire logic             serialDataLine,
  input wire logic             serialSelectLow,
  // device side
  input wire logic [7:0][15:0] portRegs,
  input wire logic             bankSelect,
  input wire logic             frameLoaded,
  input wire logic [2:0]       frameDest,
  input wire logic             commStep,
  input wire logic [2:0]       commPhase
);
  logic [15:0] frm_ff;
  logic [15:0] nxt_frm;
  logic [4:0]  cnt_ff;
  logic [4:0]  nxt_cnt;
  logic [4:0]  age_ff;
  logic [4:0]  nxt_age;
  logic        sck_ff;
  logic        rise;
  logic [2:0]  dst;
  assign rise = serialClk && !sck_ff && !serialSelectLow;
  // routed port for the odd and even banks
  assign dst  = {frm_ff[14:13], bankSelect} - 3'h1;
  always_comb begin
    nxt_frm = rise ? {frm_ff[14:0], serialDataLine} : frm_ff;
    nxt_cnt = serialSelectLow ? 5'h00 : cnt_ff + {4'h0, rise};
    // age saturates so a stray load long after a frame is seen
    nxt_age = (rise && cnt_ff == 5'h0f) ? 5'h00 : age_ff + {4'h0, age_ff != 5'h1f};
  end
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      frm_ff <= 16'h0000;
      cnt_ff <= 5'h00;
      age_ff <= 5'h1f;
      sck_ff <= 1'b0;
    end else begin
      frm_ff <= nxt_frm;
      cnt_ff <= nxt_cnt;
      age_ff <= nxt_age;
      sck_ff <= serialClk;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  chk_clk_idle: assert property (serialSelectLow |-> !serialClk)
    else $error("link clock moved outside a frame");
  chk_frame_len: assert property ($rose(serialSelectLow) |-> $past(cnt_ff) == 5'h10)
    else $error("frame not sixteen clocks");
  chk_select_gap: assert property ($rose(serialSelectLow) |=> serialSelectLow [*7])
    else $error("select gap too short");
  chk_load_time: assert property (rise && cnt_ff == 5'h0f |-> ##[2:8] frameLoaded)
    else $error("no load after sixteenth clock");
  chk_stray_load: assert property (frameLoaded |-> age_ff <= 5'h08)
    else $error("load without a whole frame");
  chk_top_route: assert property (frameLoaded && frm_ff[15] |-> frameDest == 3'h7)
    else $error("top select bit not routed to port 7");
  chk_zero_route: assert property (frameLoaded && frm_ff[15:13] == 3'h0 |-> frameDest == 3'h0)
    else $error("port 0 frame misrouted");
  chk_odd_bank: assert property (frameLoaded && !frm_ff[15] && frm_ff[14:13] != 2'h0
      && !bankSelect |-> frameDest == dst)
    else $error("odd bank misrouted");
  chk_even_bank: assert property (frameLoaded && !frm_ff[15] && frm_ff[14:13] != 2'h0
      && bankSelect |-> frameDest == dst)
    else $error("even bank misrouted");
  chk_load_value: assert property (frameLoaded && frameDest != 3'h6
      |-> portRegs[frameDest] == frm_ff)
    else $error("port holds wrong frame");
  chk_test_port: assert property (frameLoaded && frameDest == 3'h6 |=> portRegs[6] == 16'h0000)
    else $error("test port written");
  chk_manual_step: assert property (frameLoaded && frameDest == 3'h0 && frm_ff[12]
      |-> (commStep || $past(commStep)) or (##1 commStep))
    else $error("no manual step");
  chk_phase_adv: assert property (commStep && !portRegs[0][4] |=> commPhase ==
      (($past(commPhase) == 3'h5) ? 3'h0 : $past(commPhase) + 3'h1))
    else $error("phase did not advance");
endmodule

//--- testbench/testbench.sv
// Purpose: bench for host and device ends of the serial port
// Assumes: host link joins device; second link is bench driven
// Notes:   expected ports come from a decode model in the bench
`timescale 1ns/1ps
module testbench;
  logic             clk_sys  = 1'b0;
  logic             rst_n    = 1'b0;
  logic [3:0]       regAddr  = 4'h0;
  logic [15:0]      regWdata = 16'h0000;
  logic             regWr    = 1'b0;
  logic             regRd    = 1'b0;
  logic             zc       = 1'b0;
  logic [15:0]      regRdata;
  logic [7:0][15:0] portRegs;
  logic [7:0][15:0] portRegs2;
  logic             bankSelect;
  logic             frameLoaded;
  logic             frameLoaded2;
  logic             commStep;
  logic [2:0]       frameDest;
  logic [2:0]       commPhase;
  logic [15:0]      expReg [8];
  logic [2:0]       expPhase;
  logic [15:0]      rv;
  logic [15:0]      corner [12] = '{16'h0000, 16'h2abc, 16'h4d21, 16'h7e0f, 16'h1008,
    16'h2345, 16'h5a5a, 16'h6ee1, 16'hffff, 16'h1000, 16'h8001, 16'h3003};
  int               fail_count = 0;
  int               n_checks   = 0;
  int               loads2     = 0;
  always #12.5 clk_sys = ~clk_sys;
  sdsp_link_if lk ();
  sdsp_link_if lk2 ();
  sdsp_host u_sdsp_host (.clk_sys(clk_sys), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .link(lk.host));
  sdsp_device u_sdsp_device (.clk_sys(clk_sys), .rst_n(rst_n), .link(lk.dev),
    .zeroCross(zc), .portRegs(portRegs), .bankSelect(bankSelect),
    .frameLoaded(frameLoaded), .frameDest(frameDest), .commStep(commStep),
    .commPhase(commPhase));
  // second device faces the bench so it can be fed broken frames
  sdsp_device u_sdsp_device_b (.clk_sys(clk_sys), .rst_n(rst_n), .link(lk2.dev),
    .zeroCross(1'b0), .portRegs(portRegs2), .bankSelect(), .frameLoaded(frameLoaded2),
    .frameDest(), .commStep(), .commPhase());
  sdsp_assertions u_sdsp_assertions (.clk_sys(clk_sys), .rst_n(rst_n),
    .serialClk(lk.serialClk), .serialDataLine(lk.serialDataLine),
    .serialSelectLow(lk.serialSelectLow), .portRegs(portRegs), .bankSelect(bankSelect),
    .frameLoaded(frameLoaded), .frameDest(frameDest), .commStep(commStep),
    .commPhase(commPhase));
  always @(posedge clk_sys) if (frameLoaded2) loads2 <= loads2 + 1;
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk16(string what, logic [15:0] exp, logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_up();
    fail_count++;
    end_sim();
  endtask
  task automatic wr(logic [3:0] a, logic [15:0] d);
    @(posedge clk_sys);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk_sys);
    regWr    <= 1'b0;
  endtask
  task automatic rd(logic [3:0] a, output logic [15:0] d);
    @(posedge clk_sys);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk_sys);
    regRd   <= 1'b0;
    #1 d = regRdata;
  endtask
  function automatic logic [2:0] exp_dest(logic [15:0] d, logic bank);
    if (d[15]) return 3'h7;
    if (d[14:13] == 2'h0) return 3'h0;
    return {d[14:13], bank} - 3'h1;
  endfunction
  task automatic send(logic [15:0] d);
    logic [2:0] dst;
    int         i;
    dst = exp_dest(d, expReg[0][3]);
    wr(sdsp_pkg::ADDR_FRAME, d);
    // a second start while busy must be refused
    wr(sdsp_pkg::ADDR_FRAME, ~d);
    for (i = 0; i < 200 && frameLoaded !== 1'b1; i++) begin
      @(posedge clk_sys);
      #1;
    end
    if (i == 200) give_up();
    chk16("dest", {13'h0, dst}, {13'h0, frameDest});
    if (dst != 3'h6) expReg[dst] = d;
    if (dst == 3'h0 && d[12] && !d[4]) expPhase = (expPhase == 3'h5) ? 3'h0 : expPhase + 3'h1;
    for (int p = 0; p < 8; p++) chk16("port", expReg[p], portRegs[p]);
    for (i = 0; i < 60; i++) begin
      rd(sdsp_pkg::ADDR_STATUS, rv);
      if (rv[sdsp_pkg::STAT_BUSY] === 1'b0) break;
    end
    if (i == 60) give_up();
    chk16("status", 16'h0002, rv);
    rd(sdsp_pkg::ADDR_FRAME, rv);
    chk16("last frame", d, rv);
    chk16("phase", {13'h0, expPhase}, {13'h0, commPhase});
  endtask
  // bench plays host on the second link, n bits then select up
  task automatic bang(logic [15:0] d, int n);
    @(posedge clk_sys);
    lk2.serialSelectLow <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int b = 15; b > 15 - n; b--) begin
      lk2.serialDataLine <= d[b];
      repeat (4) @(posedge clk_sys);
      lk2.serialClk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      lk2.serialClk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    lk2.serialSelectLow <= 1'b1;
    lk2.serialDataLine  <= ~d[16-n];
    repeat (20) @(posedge clk_sys);
  endtask
  initial begin
    lk2.serialClk       = 1'b0;
    lk2.serialDataLine  = 1'b0;
    lk2.serialSelectLow = 1'b1;
    rv = 16'($urandom(32'he1eacfc1));
    foreach (expReg[p]) expReg[p] = 16'h0000;
    expPhase = 3'h0;
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    for (int p = 0; p < 8; p++) chk16("reset port", 16'h0000, portRegs[p]);
    rd(4'hf, rv);
    chk16("unmapped", 16'h0000, rv);
    foreach (corner[k]) send(corner[k]);
    // bit 4 kept clear so port 0 stays in software stepping
    repeat (24) send(16'($urandom) & 16'hffef);
    // hardware stepping: manual bit ignored, zero crossings advance
    send(16'h1010);
    repeat (6) begin
      @(posedge clk_sys);
      zc <= ~zc;
      repeat (3) @(posedge clk_sys);
    end
    expPhase = 3'((int'(expPhase) + 3) % 6);
    #1 chk16("hw phase", {13'h0, expPhase}, {13'h0, commPhase});
    send(16'h0000);
    wr(sdsp_pkg::ADDR_STATUS, 16'h0002);
    rd(sdsp_pkg::ADDR_STATUS, rv);
    chk16("done clear", 16'h0000, rv);
    bang(16'h9abc, 8);
    bang(16'h8765, 15);
    chk16("aborted loads", 16'h0000, 16'(loads2));
    chk16("aborted port", 16'h0000, portRegs2[7]);
    bang(16'hc3a5, 16);
    chk16("whole loads", 16'h0001, 16'(loads2));
    chk16("whole port", 16'hc3a5, portRegs2[7]);
    end_sim();
  end
endmodule
